// >>> hdl/numeric_operand_format_converter.sv
// Operand format front end: register stack, load/store conversion, error pointers.
// Assumes the host presents whole little-endian operands one per command strobe.
// One command is in flight at a time; the host waits for ready before the next.
// Stack contents are not reset; the tags alone say which registers hold values.
// Explicit register indices wrap modulo eight, as the top pointer does.
// Integer stores wrap silently on overflow below 2^64 and give zero from 2^64 up; only real stores report lost bits.
// Denormal reals load as zero; an all-ones exponent loads as the top exponent.
// A zero extended exponent stores as zero in short and long real formats.
// Error pointers keep the last fault until another fault overwrites them.
// Results stand one cycle as a strobe; the data word holds until the next store or raw read, underflowing ones included.
// Arithmetic lives elsewhere; this block only moves and converts operands.
`timescale 1ns/1ps
`default_nettype none
`include "fmt_conv_cfg.svh"
module numeric_operand_format_converter #(
    parameter int DEPTH = `STACK_DEPTH
) (
    // Clock and reset
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_nrst,
    // Command from host
    input  wire logic                  i_cmd_valid,
    input  wire fmt_conv_pkg::cmd_type i_cmd,
    input  wire logic [79:0]           i_mem_data,
    output logic                       o_cmd_ready,
    // Store result
    output logic                       o_data_valid,
    output logic      [79:0]           o_data,
    // Error reporting
    input  wire logic                  i_err_clear,
    output logic                       o_error,
    output logic      [`ADDR_W-1:0]    o_err_instr_addr,
    output logic      [`ADDR_W-1:0]    o_err_oper_addr,
    // Stack state
    output logic      [2:0]            o_top,
    output logic      [DEPTH-1:0]      o_full_tags
);
    import fmt_conv_pkg::*;

    // Register stack storage and occupancy
    logic [79:0]      stack_reg [DEPTH];
    logic [DEPTH-1:0] tag_reg;
    logic [2:0]       top_reg;

    // Command and operand word waiting for their execute cycle
    logic             pend_reg;
    cmd_type          pend_cmd_reg;
    logic [79:0]      mem_lat_reg;

    // Result towards the host
    logic [79:0]      data_reg;
    logic             dvalid_reg;

    // Deferred error report
    logic             err_reg;
    logic [`ADDR_W-1:0] instr_ptr_reg;
    logic [`ADDR_W-1:0] oper_ptr_reg;

    // Converter shares one format select for load and store
    logic [79:0] ext_in;
    logic [79:0] mem_out;
    logic        inexact;

    // Top-relative index, wraps modulo eight
    function automatic logic [2:0] rel_idx(input logic [2:0] top, input logic [2:0] off);
        return 3'(top + off);
    endfunction

    // Command accepted one at a time; execution is one cycle later
    wire       take      = i_cmd_valid && o_cmd_ready;

    // Stack indices: push goes down, pop goes up, explicit is top-relative
    wire [2:0] push_idx  = 3'(top_reg - 3'h1);
    wire [2:0] pop_idx   = 3'(top_reg + 3'h1);
    wire [2:0] expl_idx  = rel_idx(top_reg, pend_cmd_reg.reg_idx);

    // Decode of the pending operation, live only in its execute cycle
    wire       is_load   = pend_reg && pend_cmd_reg.op == OP_LOAD;
    wire       is_store  = pend_reg && (pend_cmd_reg.op == OP_STORE || pend_cmd_reg.op == OP_STORE_POP);
    wire       is_pop    = pend_reg && pend_cmd_reg.op == OP_STORE_POP;
    wire       is_rd     = pend_reg && pend_cmd_reg.op == OP_READ_REG;
    wire       is_wr     = pend_reg && pend_cmd_reg.op == OP_WRITE_REG;

    // Refusals; any of them leaves the stack as it was
    wire       overflow  = is_load && tag_reg[push_idx];
    wire       underflow = (is_store && !tag_reg[top_reg]) || (is_rd && !tag_reg[expl_idx]);
    wire       fault     = overflow || underflow || (is_store && inexact);

    // Register selection for stores, raw reads and writes
    wire [79:0] src_val  = is_rd ? stack_reg[expl_idx] : stack_reg[top_reg];
    wire        wr_en    = (is_load && !fault) || is_wr;
    wire [2:0]  wr_idx   = is_load ? push_idx : expl_idx;

    // Next values of the top pointer, result strobe and error flag
    wire [2:0]  top_next = fault ? top_reg : is_load ? push_idx : is_pop ? pop_idx : top_reg;
    wire        dv_next  = (is_store || is_rd) && !underflow;
    wire        err_next = fault || (err_reg && !i_err_clear); // Set wins over clear

    // Store side of the converter reads the selected register
    assign ext_in       = src_val;

    // Handshake is combinational: ready whenever nothing waits to execute
    assign o_cmd_ready  = !pend_reg;

    // Remaining outputs come straight from flip-flops
    assign o_data_valid = dvalid_reg;
    assign o_data       = data_reg;
    assign o_error      = err_reg;
    assign o_err_instr_addr = instr_ptr_reg;
    assign o_err_oper_addr  = oper_ptr_reg;
    assign o_top        = top_reg;
    assign o_full_tags  = tag_reg;

    // Conversion unit; one format select serves both directions, one op at a time
    logic [79:0] load_ext;
    fmt_unit u_fmt (
        .i_mem_word (mem_lat_reg),
        .i_fmt      (pend_cmd_reg.fmt),
        .o_ext      (load_ext),
        .i_ext      (ext_in),
        .o_mem_word (mem_out),
        .o_inexact  (inexact)
    );

    // Latch command and operand word; bytes arrive little-endian already packed
    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            pend_reg     <= 1'b0;
            pend_cmd_reg <= '0;
            mem_lat_reg  <= 80'h0;
        end else begin
            pend_reg <= take;
            if (take) begin
                pend_cmd_reg <= i_cmd;
                mem_lat_reg  <= i_mem_data;
            end
        end
    end

    // Stack top pointer; a faulting op leaves it where it was
    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            top_reg <= 3'h0;
        end else begin
            top_reg <= top_next;
        end
    end

    // Occupancy tags, one per physical register
    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            tag_reg <= '0;
        end else if (!fault) begin
            if (wr_en) begin
                tag_reg[wr_idx] <= 1'b1;
            end else if (is_pop) begin
                tag_reg[top_reg] <= 1'b0;
            end
        end
    end

    // Data registers; no reset, since the tags mark them empty
    always_ff @(posedge i_clk_sys) begin
        if (wr_en) begin
            stack_reg[wr_idx] <= load_ext;
        end
    end

    // Store result, or raw register read; the word holds until the next store or raw read, even one refused by underflow
    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            dvalid_reg <= 1'b0;
            data_reg   <= 80'h0;
        end else begin
            dvalid_reg <= dv_next;
            if (is_store || is_rd) begin
                data_reg <= is_rd ? src_val : mem_out;
            end
        end
    end

    // Sticky error flag; a fault in the clear cycle wins
    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            err_reg <= 1'b0;
        end else begin
            err_reg <= err_next;
        end
    end

    // Pointers capture failing addresses; reported after the host moved on
    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            instr_ptr_reg <= '0;
            oper_ptr_reg  <= '0;
        end else if (fault) begin
            instr_ptr_reg <= pend_cmd_reg.instr_addr;
            if (pend_cmd_reg.has_oper) begin
                oper_ptr_reg <= pend_cmd_reg.oper_addr;
            end
        end
    end
endmodule // numeric_operand_format_converter
`default_nettype wire

// >>> shared/fmt_conv_cfg.svh
// Constants for the operand format converter: field positions, biases, sizes.
// Assumes inclusion by bare name from the package and design files.
`ifndef FMT_CONV_CFG_SVH
`define FMT_CONV_CFG_SVH
`define EXT_W          80
`define EXT_SIGN       79
`define EXT_EXP_HI     78
`define EXT_EXP_LO     64
`define EXT_BIAS       15'h3fff
`define SR_SIGN        31
`define SR_EXP_HI      30
`define SR_EXP_LO      23
`define SR_FRAC_HI     22
`define SR_BIAS        15'h007f
`define LR_SIGN        63
`define LR_EXP_HI      62
`define LR_EXP_LO      52
`define LR_FRAC_HI     51
`define LR_BIAS        15'h03ff
`define BCD_SIGN       79
`define BCD_DIGITS     18
`define STACK_DEPTH    8
`define ADDR_W         32
`define INT_ONE_POS    63
`endif

// >>> shared/fmt_conv_pkg.sv
// Types shared by the operand format converter and its conversion unit.
// Assumes fmt_conv_cfg.svh is reachable on the include path.
`include "fmt_conv_cfg.svh"
package fmt_conv_pkg;
    // Memory operand formats
    typedef enum logic [2:0] {
        FMT_WORD_INT, FMT_SHORT_INT, FMT_LONG_INT,
        FMT_SHORT_REAL, FMT_LONG_REAL, FMT_BCD, FMT_EXT
    } mem_fmt_type;
    // Stack operation requested by the host
    typedef enum logic [2:0] {
        OP_NONE, OP_LOAD, OP_STORE, OP_STORE_POP, OP_READ_REG, OP_WRITE_REG
    } stack_op_type;
    // Extended value as fields
    typedef struct packed {
        logic        sign;
        logic [14:0] exp;
        logic [63:0] sig;
    } ext_type;
    // Command carried with one instruction
    typedef struct packed {
        stack_op_type          op;
        mem_fmt_type           fmt;
        logic [2:0]            reg_idx;
        logic [`ADDR_W-1:0]    instr_addr;
        logic [`ADDR_W-1:0]    oper_addr;
        logic                  has_oper;
    } cmd_type;
endpackage

// >>> hdl/fmt_unit.sv
// Combinational conversion between memory operand formats and the extended format.
// Assumes operand bytes already assembled little-endian into an 80-bit word.
`timescale 1ns/1ps
`default_nettype none
`include "fmt_conv_cfg.svh"
module fmt_unit (
    // Load path
    input  wire logic [79:0]               i_mem_word,
    input  wire fmt_conv_pkg::mem_fmt_type i_fmt,
    output logic      [79:0]               o_ext,
    // Store path
    input  wire logic [79:0]               i_ext,
    output logic      [79:0]               o_mem_word,
    output logic                           o_inexact
);
    import fmt_conv_pkg::*;

    // Leading-zero count for normalising integers
    function automatic logic [6:0] lzc64(input logic [63:0] v);
        logic [6:0] n;
        n = 7'h40;
        for (int k = 0; k < 64; k++) begin
            if (v[k]) begin
                n = 7'(63 - k);
            end
        end
        return n;
    endfunction

    // Integer magnitude to extended
    function automatic logic [79:0] int_to_ext(input logic s, input logic [63:0] mag);
        logic [6:0] z;
        z = lzc64(mag);
        if (mag == 64'h0) begin
            return {s, 79'h0};
        end
        return {s, 15'(`EXT_BIAS + 15'(7'd63 - z)), 64'(mag << z)};
    endfunction

    // Real to extended, biases rebased; denormals treated as zero
    function automatic logic [79:0] real_to_ext(input logic s, input logic [14:0] e,
                                                input logic [63:0] f, input logic [14:0] bias,
                                                input logic emax);
        if (e == 15'h0) begin
            return {s, 79'h0};
        end
        if (emax) begin
            return {s, 15'h7fff, 1'b1, f[62:0]};
        end
        return {s, 15'(e - bias + `EXT_BIAS), 1'b1, f[62:0]};
    endfunction

    // Load-side decode of each format
    wire [63:0] w_i16  = 64'(signed'(i_mem_word[15:0]));
    wire [63:0] w_i32  = 64'(signed'(i_mem_word[31:0]));
    wire [63:0] w_i64  = i_mem_word[63:0];
    logic [63:0] int_val;
    logic [63:0] bcd_bin;

    // BCD digits to binary; sign byte low bits ignored
    always_comb begin
        bcd_bin = 64'h0;
        for (int d = `BCD_DIGITS - 1; d >= 0; d--) begin
            bcd_bin = 64'(bcd_bin * 64'd10) + 64'(i_mem_word[d*4 +: 4]);
        end
    end

    // Load conversion; integer formats take a two's complement sign from their top bit
    always_comb begin
        int_val = 64'h0;
        o_ext   = 80'h0;
        unique case (i_fmt)
            FMT_WORD_INT, FMT_SHORT_INT, FMT_LONG_INT: begin
                int_val = (i_fmt == FMT_WORD_INT) ? w_i16 : (i_fmt == FMT_SHORT_INT) ? w_i32 : w_i64;
                o_ext   = int_to_ext(int_val[63], int_val[63] ? 64'(-int_val) : int_val);
            end
            FMT_SHORT_REAL:
                o_ext = real_to_ext(i_mem_word[`SR_SIGN], 15'(i_mem_word[`SR_EXP_HI:`SR_EXP_LO]),
                                    {1'b1, i_mem_word[`SR_FRAC_HI:0], 40'h0}, `SR_BIAS,
                                    &i_mem_word[`SR_EXP_HI:`SR_EXP_LO]);
            FMT_LONG_REAL:
                o_ext = real_to_ext(i_mem_word[`LR_SIGN], 15'(i_mem_word[`LR_EXP_HI:`LR_EXP_LO]),
                                    {1'b1, i_mem_word[`LR_FRAC_HI:0], 11'h0}, `LR_BIAS,
                                    &i_mem_word[`LR_EXP_HI:`LR_EXP_LO]);
            FMT_BCD:
                o_ext = int_to_ext(i_mem_word[`BCD_SIGN], bcd_bin);
            FMT_EXT:
                o_ext = i_mem_word;
            default:
                o_ext = 80'h0;
        endcase
    end

    // Store-side field split
    wire        s_sign = i_ext[`EXT_SIGN];
    wire [14:0] s_exp  = i_ext[`EXT_EXP_HI:`EXT_EXP_LO];
    wire [63:0] s_sig  = i_ext[63:0];
    wire        s_zero = (s_exp == 15'h0);
    wire [14:0] s_ub   = s_exp - `EXT_BIAS;
    wire        s_neg  = s_exp < `EXT_BIAS;
    wire [63:0] s_mag  = (s_neg || s_ub > 15'd63) ? 64'h0 : s_sig >> (6'(7'd63 - 7'(s_ub)));
    wire [63:0] s_int  = s_sign ? 64'(-s_mag) : s_mag;
    wire [14:0] s_e32  = s_exp - `EXT_BIAS + `SR_BIAS;
    wire [14:0] s_e64  = s_exp - `EXT_BIAS + `LR_BIAS;
    logic [71:0] bcd_out;
    logic [63:0] bin_rem;

    // Binary to BCD by repeated division, eighteen digits
    always_comb begin
        bin_rem = s_mag;
        bcd_out = 72'h0;
        for (int d = 0; d < `BCD_DIGITS; d++) begin
            bcd_out[d*4 +: 4] = 4'(bin_rem % 64'd10);
            bin_rem = bin_rem / 64'd10;
        end
    end

    // Store conversion; truncation toward zero, inexact flagged for short and long real only
    always_comb begin
        o_mem_word = 80'h0;
        o_inexact  = 1'b0;
        unique case (i_fmt)
            FMT_WORD_INT:   o_mem_word = {64'h0, s_int[15:0]};
            FMT_SHORT_INT:  o_mem_word = {48'h0, s_int[31:0]};
            FMT_LONG_INT:   o_mem_word = {16'h0, s_int};
            FMT_SHORT_REAL: begin
                o_mem_word = s_zero ? {48'h0, s_sign, 31'h0}
                           : {48'h0, s_sign, s_e32[7:0], s_sig[62:40]};
                o_inexact  = |s_sig[39:0];
            end
            FMT_LONG_REAL: begin
                o_mem_word = s_zero ? {16'h0, s_sign, 63'h0}
                           : {16'h0, s_sign, s_e64[10:0], s_sig[62:11]};
                o_inexact  = |s_sig[10:0];
            end
            FMT_BCD:        o_mem_word = {s_sign, 7'h0, bcd_out};
            FMT_EXT:        o_mem_word = i_ext;
            default:        o_mem_word = 80'h0;
        endcase
    end
endmodule // fmt_unit
`default_nettype wire

// >>> verif/numeric_operand_format_converter_assertions.sv
// Port checks for the operand format converter.
// Assumes results, flags and stack state land two edges after a take.
`timescale 1ns/1ps
`default_nettype none
module fmt_conv_checker
    import fmt_conv_pkg::*;
#(parameter int DEPTH = 8) (
    // Watched ports
    input wire logic             i_clk_sys,
    input wire logic             i_nrst,
    input wire logic             i_cmd_valid,
    input wire cmd_type          i_cmd,
    input wire logic             o_cmd_ready,
    input wire logic             o_data_valid,
    input wire logic [79:0]      o_data,
    input wire logic             i_err_clear,
    input wire logic             o_error,
    input wire logic [31:0]      o_err_instr_addr,
    input wire logic [31:0]      o_err_oper_addr,
    input wire logic [2:0]       o_top
);
    // A command counts only when both sides agree on the edge
    wire logic take;
    assign take = i_cmd_valid && o_cmd_ready;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);
    ready_drop_a: assert property (take |=> !o_cmd_ready)
        else $error("ready stayed high after a take");
    valid_pulse_a: assert property (o_data_valid |=> !o_data_valid)
        else $error("data valid longer than one cycle");
    store_answer_a: assert property (take && i_cmd.op inside {OP_STORE, OP_STORE_POP} |-> ##2 (o_data_valid || o_error))
        else $error("store gave neither data nor error");
    push_top_a: assert property (take && i_cmd.op == OP_LOAD |-> ##2 (o_error || o_top == 3'($past(o_top, 2) - 3'h1)))
        else $error("push did not lower top by one");
    pop_top_a: assert property (take && i_cmd.op == OP_STORE_POP |-> ##2 (o_error || o_top == 3'($past(o_top, 2) + 3'h1)))
        else $error("pop did not raise top by one");
    keep_top_a: assert property (take && i_cmd.op inside {OP_STORE, OP_READ_REG, OP_WRITE_REG} |-> ##2 o_top == $past(o_top, 2))
        else $error("explicit access moved top");
    ptr_capture_a: assert property ($rose(o_error) |-> o_err_instr_addr == $past(i_cmd.instr_addr, 2))
        else $error("instruction pointer not captured");
    oper_capture_a: assert property ($rose(o_error) && $past(i_cmd.has_oper, 2) |-> o_err_oper_addr == $past(i_cmd.oper_addr, 2))
        else $error("operand pointer not captured");
    err_sticky_a: assert property (o_error && !i_err_clear |=> o_error)
        else $error("error dropped without clear");
    bcd_spare_a: assert property (o_data_valid && $past(i_cmd.fmt, 2) == FMT_BCD && $past(i_cmd.op, 2) != OP_READ_REG |-> o_data[78:72] == 7'h00)
        else $error("packed decimal spare bits not zero");
    // Main scenarios reached
    cov_push_c: cover property (take && i_cmd.op == OP_LOAD);
    cov_pop_c: cover property (take && i_cmd.op == OP_STORE_POP);
    cov_fault_c: cover property ($rose(o_error));
endmodule // fmt_conv_checker
bind numeric_operand_format_converter fmt_conv_checker #(.DEPTH(DEPTH)) chk_u (.i_clk_sys, .i_nrst, .i_cmd_valid,
    .i_cmd, .o_cmd_ready, .o_data_valid, .o_data, .i_err_clear, .o_error, .o_err_instr_addr, .o_err_oper_addr, .o_top);
`default_nettype wire

// >>> verif/host_cpu_model.sv
// Host side model: issues one command and collects its answer.
// Assumes the converter takes on ready and answers within three edges.
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model
    import fmt_conv_pkg::*;
(
    // Answers from the converter
    input  wire logic        i_clk_sys,
    input  wire logic        i_cmd_ready,
    input  wire logic        i_data_valid,
    input  wire logic [79:0] i_data,
    input  wire logic        i_error,
    // Command channel
    output var logic         o_cmd_valid,
    output var cmd_type      o_cmd,
    output var logic [79:0]  o_mem_data
);
    logic [31:0] last_ip = 32'h0000_0100;
    logic [31:0] last_op = 32'h0000_0000;
    initial begin
        o_cmd_valid = 1'b0;
        o_cmd = '0;
        o_mem_data = 80'h0;
    end
    // Hold everything until ready is seen, then release the bus
    task automatic issue(input stack_op_type op, input mem_fmt_type f, input logic [2:0] ix,
                         input logic [79:0] w, output logic v, output logic [79:0] d, output logic e);
        int n;
        v = 1'b0;
        d = 80'h0;
        n = 0;
        @(posedge i_clk_sys);
        last_ip = last_ip + 32'h4;
        last_op = {last_ip[27:0], 4'h0};
        o_cmd_valid <= 1'b1;
        o_cmd <= '{op, f, ix, last_ip, last_op, op inside {OP_LOAD, OP_STORE, OP_STORE_POP}};
        o_mem_data <= w;
        do begin
            @(posedge i_clk_sys);
            n++;
        end while (!i_cmd_ready && n < 16);
        o_cmd_valid <= 1'b0;
        o_mem_data <= ~w; // Released bus must not look like live data
        repeat (3) begin
            @(posedge i_clk_sys);
            if (i_data_valid) begin
                v = 1'b1;
                d = i_data;
            end
        end
        e = i_error;
    endtask
endmodule // host_cpu_model
`default_nettype wire

// >>> verif/numeric_operand_format_converter_tb_top.sv
// Self-checking bench for the operand format converter.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module numeric_operand_format_converter_tb_top;
    import fmt_conv_pkg::*;
    logic             clk = 1'b0;
    logic             nrst = 1'b0;
    logic             clr = 1'b0;
    wire logic        cv, rdy, dv, err;
    wire cmd_type     cmd;
    wire logic [79:0] md, dat;
    wire logic [31:0] eia, eoa;
    wire logic [2:0]  top;
    wire logic [7:0]  tags;
    int               n_fail = 0;
    int               checked = 0;
    int               cyc = 0;
    logic             g_v, g_e;
    logic [79:0]      g_d;
    // Operands per format: memory in, extended, width
    logic [79:0] mi [7] = '{80'hfffb, 80'h100, 80'h1, 80'h3fc0_0000, 80'hc000_0000_0000_0000,
                            80'h5500_0000_0000_0000_1234, 80'hbffe_c000_0000_0000_0000};
    logic [79:0] me [7] = '{80'hc001_a000_0000_0000_0000, 80'h4007_8000_0000_0000_0000,
                            80'h3fff_8000_0000_0000_0000, 80'h3fff_c000_0000_0000_0000,
                            80'hc000_8000_0000_0000_0000, 80'h4009_9a40_0000_0000_0000,
                            80'hbffe_c000_0000_0000_0000};
    int          wb [7] = '{16, 32, 64, 32, 64, 80, 80};
    always #4 clk = ~clk;
    numeric_operand_format_converter dut_u (.i_clk_sys(clk), .i_nrst(nrst), .i_cmd_valid(cv), .i_cmd(cmd),
        .i_mem_data(md), .o_cmd_ready(rdy), .o_data_valid(dv), .o_data(dat), .i_err_clear(clr), .o_error(err),
        .o_err_instr_addr(eia), .o_err_oper_addr(eoa), .o_top(top), .o_full_tags(tags));
    host_cpu_model host_u (.i_clk_sys(clk), .i_cmd_ready(rdy), .i_data_valid(dv), .i_data(dat), .i_error(err),
        .o_cmd_valid(cv), .o_cmd(cmd), .o_mem_data(md));
    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(string nm, logic [79:0] e, logic [79:0] g);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic run(stack_op_type op, mem_fmt_type f, logic [2:0] ix, logic [79:0] w);
        host_u.issue(op, f, ix, w, g_v, g_d, g_e);
    endtask
    task automatic clear_err();
        @(posedge clk) clr <= 1'b1;
        @(posedge clk) clr <= 1'b0;
        @(posedge clk) chk("error cleared", 80'h0, 80'(err));
    endtask
    // Each format: load, read back raw, store and pop
    task automatic t_formats();
        for (int i = 0; i < 7; i++) begin
            logic [79:0] want;
            want = (mem_fmt_type'(i) == FMT_BCD) ? mi[i] & ~(80'h7f << 72) : mi[i]; // Spare bits come back zero
            run(OP_LOAD, mem_fmt_type'(i), 3'h0, mi[i]);
            chk("push top", 80'h7, 80'(top));
            chk("tag set", 80'h1, 80'(tags[7]));
            run(OP_READ_REG, FMT_EXT, 3'h0, 80'h0);
            chk("extended value", me[i], g_d);
            run(OP_STORE_POP, mem_fmt_type'(i), 3'h0, 80'h0);
            chk("stored operand", want, g_d & ({80{1'b1}} >> (80 - wb[i])));
            chk("pop top", 80'h0, 80'(top));
        end
    endtask
    // Top-relative access to a deeper register
    task automatic t_explicit();
        run(OP_LOAD, FMT_EXT, 3'h0, me[2]);
        run(OP_LOAD, FMT_EXT, 3'h0, me[3]);
        run(OP_READ_REG, FMT_EXT, 3'h1, 80'h0);
        chk("explicit read", me[2], g_d);
        run(OP_WRITE_REG, FMT_EXT, 3'h1, me[4]);
        run(OP_STORE, FMT_EXT, 3'h0, 80'h0);
        chk("top untouched", me[3], g_d);
        run(OP_STORE_POP, FMT_EXT, 3'h0, 80'h0);
        run(OP_STORE_POP, FMT_SHORT_REAL, 3'h0, 80'h0);
        chk("written register", 80'hc000_0000, g_d & 80'hffff_ffff);
    endtask
    // Ninth push overflows, ninth pop underflows
    task automatic t_overflow();
        for (int i = 0; i < 9; i++) run(OP_LOAD, FMT_LONG_INT, 3'h0, 80'(i));
        chk("overflow error", 80'h1, 80'(err));
        chk("fault instr addr", 80'(host_u.last_ip), 80'(eia));
        chk("fault oper addr", 80'(host_u.last_op), 80'(eoa));
        chk("stack full", 80'hff, 80'(tags));
        clear_err();
        for (int i = 0; i < 8; i++) begin
            run(OP_STORE_POP, FMT_LONG_INT, 3'h0, 80'h0);
            chk("pop order", 80'(7 - i), g_d & 80'hffff_ffff_ffff_ffff);
        end
        run(OP_STORE_POP, FMT_LONG_INT, 3'h0, 80'h0);
        chk("underflow no data", 80'h0, 80'(g_v));
        chk("underflow error", 80'h1, 80'(g_e));
        clear_err();
    endtask
    // Inexact real store truncates, reports, keeps the stack; integer stores truncate quietly
    task automatic t_inexact();
        run(OP_LOAD, FMT_EXT, 3'h0, 80'h3fff_c000_0000_0000_0001);
        run(OP_STORE_POP, FMT_SHORT_REAL, 3'h0, 80'h0);
        chk("truncated store", 80'h3fc0_0000, g_d & 80'hffff_ffff);
        chk("inexact error", 80'h1, 80'(g_e));
        chk("stack kept", 80'h7, 80'(top));
        clear_err();
        run(OP_STORE_POP, FMT_WORD_INT, 3'h0, 80'h0);
        chk("integer truncation", 80'h1, g_d & 80'hffff);
        chk("integer pop top", 80'h0, 80'(top));
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_fail++;
            close_out();
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        chk("reset state", 80'h1, {err, dv, top, tags, rdy});
        t_formats();
        t_explicit();
        t_overflow();
        t_inexact();
        close_out();
    end
endmodule // numeric_operand_format_converter_tb_top
`default_nettype wire
